// file: hdl/bcf_defines.vh
// Constants for the bridge control and legacy video forwarding block.
// Included by bare name from every design file of the block.
`ifndef BCF_DEFINES_VH
`define BCF_DEFINES_VH

// Register byte offsets
`define BCF_ADDR_W          8
`define BCF_OFS_BRIDGE_CTL  8'h00
`define BCF_OFS_COMMAND     8'h04
`define BCF_OFS_INT_STATUS  8'h08
`define BCF_OFS_INT_MASK    8'h0C
`define BCF_OFS_STATE       8'h10

// Bridge control fields
`define BCF_CTL_W           16
`define BCF_CTL_RESET       16'h0000
`define BCF_CTL_WMASK       16'h0AFF
`define BCF_BIT_B2B         7
`define BCF_BIT_SEC_RESET   6
`define BCF_BIT_ABORT_MODE  5
`define BCF_BIT_VID16       4
`define BCF_BIT_VIDEN       3
`define BCF_BIT_LEGACY_IO   2

// Command fields
`define BCF_CMD_W           2
`define BCF_CMD_RESET       2'h0
`define BCF_BIT_IO_EN       0
`define BCF_BIT_MEM_EN      1

// Interrupt status and mask fields
`define BCF_INT_W           3
`define BCF_INT_RESET       3'h0
`define BCF_INT_POSTED_MA   0
`define BCF_INT_MA_CPL      1
`define BCF_INT_TGT_ABORT   2

// Legacy video address ranges
`define BCF_VMEM_LO         32'h000A0000
`define BCF_VMEM_HI         32'h000BFFFF
`define BCF_VIO_A_LO        10'h3B0
`define BCF_VIO_A_HI        10'h3BB
`define BCF_VIO_B_LO        10'h3C0
`define BCF_VIO_B_HI        10'h3DF

// Misc values
`define BCF_ALL_ONES        32'hFFFFFFFF
`define BCF_RESP_OKAY       2'h0
`define BCF_RESP_SLVERR     2'h2

`endif

// file: hdl/bcf_video_decode.v
// Legacy video address match, purely combinational.
// Caller qualifies the match with the enable bit, and the downstream match also with the space enable bits.
`timescale 1ns/1ps
`default_nettype none
`include "bcf_defines.vh"

module bcf_video_decode (
    input  wire [31:0] addr,
    input  wire        is_io,
    input  wire        full_decode,
    output wire        hit
);

    wire [9:0] low10;
    wire       io_low_ok;
    wire       io_alias_ok;
    wire       io_hit;
    wire       mem_hit;

    assign low10       = addr[9:0];
    assign io_low_ok   = ((low10 >= `BCF_VIO_A_LO) && (low10 <= `BCF_VIO_A_HI)) ||
                         ((low10 >= `BCF_VIO_B_LO) && (low10 <= `BCF_VIO_B_HI));
    // Alias bits only matter under full decode
    assign io_alias_ok = !full_decode || (addr[15:10] == 6'h00);
    assign io_hit      = (addr[31:16] == 16'h0000) && io_low_ok && io_alias_ok;
    assign mem_hit     = (addr >= `BCF_VMEM_LO) && (addr <= `BCF_VMEM_HI);
    assign hit         = is_io ? io_hit : mem_hit;

endmodule

`default_nettype wire

// file: hdl/bcf_bridge_control.v
// Bridge control register bank with legacy video forwarding and abort handling.
// Assumes an AXI4-Lite master on aclk and transaction logic on the same clock.
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "bcf_defines.vh"

module bcf_bridge_control (
    input  wire        aclk,
    input  wire        aresetn,
    // AXI4-Lite slave
    input  wire [7:0]  awaddr,
    input  wire        awvalid,
    output reg         awready,
    input  wire [31:0] wdata,
    input  wire [3:0]  wstrb,
    input  wire        wvalid,
    output reg         wready,
    output reg  [1:0]  bresp,
    output reg         bvalid,
    input  wire        bready,
    input  wire [7:0]  araddr,
    input  wire        arvalid,
    output reg         arready,
    output reg  [31:0] rdata,
    output reg  [1:0]  rresp,
    output reg         rvalid,
    input  wire        rready,
    // Downstream request decode
    input  wire        dn_req_valid,
    input  wire [31:0] dn_req_addr,
    input  wire        dn_req_is_io,
    output reg         dn_claim,
    // Upstream request decode
    input  wire        up_req_valid,
    input  wire [31:0] up_req_addr,
    input  wire        up_req_is_io,
    output reg         up_block,
    // Master abort seen on the secondary bus
    input  wire        ma_valid,
    input  wire        ma_is_read,
    input  wire        ma_is_posted,
    output reg         cpl_valid,
    output reg         cpl_ur,
    output reg  [31:0] cpl_rdata,
    output reg         wr_discard,
    output reg         err_posted_ma,
    // Unsupported request completion from the primary link
    input  wire        ur_cpl_valid,
    input  wire        ur_cpl_is_read,
    output reg         up_cpl_valid,
    output reg         up_target_abort,
    output reg  [31:0] up_cpl_rdata,
    // Control levels
    output reg         secondary_back_to_back_enable,
    output reg         secondary_reset_out,
    output reg         legacy_io_block_enable,
    output reg         io_space_enable,
    output reg         memory_space_enable,
    output reg         irq
);

    reg  [15:0] bridge_control;
    reg  [1:0]  command;
    reg  [2:0]  int_status;
    reg  [2:0]  int_mask;

    reg         aw_got;
    reg         w_got;
    reg  [7:0]  aw_addr;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;

    reg         next_aw_got;
    reg         next_w_got;
    reg         next_bvalid;
    reg         next_rvalid;
    reg  [2:0]  next_int_status;
    reg  [31:0] read_word;
    reg         read_ok;
    reg  [15:0] ctl_written;

    wire        aw_hs;
    wire        w_hs;
    wire        ar_hs;
    wire        do_write;
    wire        abort_mode;
    wire        video_en;
    wire        full_decode;
    wire        dn_hit;
    wire        up_hit;
    wire        dn_space_ok;
    wire [2:0]  int_events;
    wire [2:0]  int_clear;

    // Byte-lane merge for the 16-bit control register
    function [15:0] merge16;
        input [15:0] old_val;
        input [31:0] new_val;
        input [3:0]  strb;
        input [15:0] wmask;
        reg   [15:0] lanes;
        begin
            lanes   = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
            merge16 = (old_val & ~lanes) | (new_val[15:0] & lanes);
        end
    endfunction

    assign aw_hs       = awvalid && awready;
    assign w_hs        = wvalid && wready;
    assign ar_hs       = arvalid && arready;
    assign do_write    = aw_got && w_got && !bvalid;

    assign abort_mode  = bridge_control[`BCF_BIT_ABORT_MODE];
    assign video_en    = bridge_control[`BCF_BIT_VIDEN];
    assign full_decode = bridge_control[`BCF_BIT_VID16] && video_en;

    bcf_video_decode u_dn_decode (
        .addr        (dn_req_addr),
        .is_io       (dn_req_is_io),
        .full_decode (full_decode),
        .hit         (dn_hit)
    );

    bcf_video_decode u_up_decode (
        .addr        (up_req_addr),
        .is_io       (up_req_is_io),
        .full_decode (full_decode),
        .hit         (up_hit)
    );

    // Space enable gates downstream video forwarding
    assign dn_space_ok = dn_req_is_io ? command[`BCF_BIT_IO_EN] :
                                        command[`BCF_BIT_MEM_EN];

    // AXI write channel bookkeeping
    always @* begin
        next_aw_got = aw_got;
        next_w_got  = w_got;
        next_bvalid = bvalid;
        if (aw_hs) begin
            next_aw_got = 1'b1;
        end
        if (w_hs) begin
            next_w_got = 1'b1;
        end
        if (do_write) begin
            next_aw_got = 1'b0;
            next_w_got  = 1'b0;
            next_bvalid = 1'b1;
        end else if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
    end

    always @* begin
        next_rvalid = rvalid;
        if (ar_hs) begin
            next_rvalid = 1'b1;
        end else if (rvalid && rready) begin
            next_rvalid = 1'b0;
        end
    end

    // Read mux
    always @* begin
        read_word = 32'h00000000;
        read_ok   = 1'b1;
        case (araddr)
            `BCF_OFS_BRIDGE_CTL: read_word = {16'h0000, bridge_control};
            `BCF_OFS_COMMAND:    read_word = {30'h00000000, command};
            `BCF_OFS_INT_STATUS: read_word = {29'h00000000, int_status};
            `BCF_OFS_INT_MASK:   read_word = {29'h00000000, int_mask};
            `BCF_OFS_STATE:      read_word = {30'h00000000, irq, secondary_reset_out};
            default:             read_ok   = 1'b0;
        endcase
    end

    // Events and write-one-to-clear
    assign int_events[`BCF_INT_POSTED_MA] = ma_valid && ma_is_posted && abort_mode;
    assign int_events[`BCF_INT_MA_CPL]    = ma_valid && !ma_is_posted && abort_mode;
    assign int_events[`BCF_INT_TGT_ABORT] = ur_cpl_valid && abort_mode;
    assign int_clear = (do_write && (aw_addr == `BCF_OFS_INT_STATUS) && w_strb[0]) ?
                       w_data[2:0] : 3'h0;

    always @* begin
        // Set wins over clear
        next_int_status = (int_status & ~int_clear) | int_events;
    end

    always @* begin
        ctl_written = merge16(bridge_control, w_data, w_strb, `BCF_CTL_WMASK);
    end

    // AXI handshake registers
    always @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b0;
            wready  <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= `BCF_RESP_OKAY;
            aw_got  <= 1'b0;
            w_got   <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h00000000;
            w_strb  <= 4'h0;
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h00000000;
            rresp   <= `BCF_RESP_OKAY;
        end else begin
            aw_got  <= next_aw_got;
            w_got   <= next_w_got;
            bvalid  <= next_bvalid;
            awready <= !next_aw_got && !next_bvalid;
            wready  <= !next_w_got && !next_bvalid;
            if (aw_hs) begin
                aw_addr <= awaddr;
            end
            if (w_hs) begin
                w_data <= wdata;
                w_strb <= wstrb;
            end
            if (do_write) begin
                case (aw_addr)
                    `BCF_OFS_BRIDGE_CTL,
                    `BCF_OFS_COMMAND,
                    `BCF_OFS_INT_STATUS,
                    `BCF_OFS_INT_MASK,
                    `BCF_OFS_STATE: bresp <= `BCF_RESP_OKAY;
                    default:        bresp <= `BCF_RESP_SLVERR;
                endcase
            end
            rvalid  <= next_rvalid;
            arready <= !next_rvalid;
            if (ar_hs) begin
                rdata <= read_word;
                rresp <= read_ok ? `BCF_RESP_OKAY : `BCF_RESP_SLVERR;
            end
        end
    end

    // Software-visible registers
    always @(posedge aclk) begin
        if (!aresetn) begin
            bridge_control <= `BCF_CTL_RESET;
            command        <= `BCF_CMD_RESET;
            int_status     <= `BCF_INT_RESET;
            int_mask       <= `BCF_INT_RESET;
        end else begin
            int_status <= next_int_status;
            if (do_write) begin
                case (aw_addr)
                    `BCF_OFS_BRIDGE_CTL: bridge_control <= ctl_written;
                    `BCF_OFS_COMMAND: begin
                        if (w_strb[0]) begin
                            command <= w_data[1:0];
                        end
                    end
                    `BCF_OFS_INT_MASK: begin
                        if (w_strb[0]) begin
                            int_mask <= w_data[2:0];
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // Control levels toward the bus interfaces
    always @(posedge aclk) begin
        if (!aresetn) begin
            secondary_back_to_back_enable <= 1'b0;
            secondary_reset_out           <= 1'b0;
            legacy_io_block_enable        <= 1'b0;
            io_space_enable               <= 1'b0;
            memory_space_enable           <= 1'b0;
            irq                           <= 1'b0;
        end else begin
            secondary_back_to_back_enable <= bridge_control[`BCF_BIT_B2B];
            // Follows the bit level, so it holds until software clears it
            secondary_reset_out           <= bridge_control[`BCF_BIT_SEC_RESET];
            legacy_io_block_enable        <= bridge_control[`BCF_BIT_LEGACY_IO];
            io_space_enable               <= command[`BCF_BIT_IO_EN];
            memory_space_enable           <= command[`BCF_BIT_MEM_EN];
            irq                           <= |(next_int_status & int_mask);
        end
    end

    // Legacy video claim and block
    always @(posedge aclk) begin
        if (!aresetn) begin
            dn_claim <= 1'b0;
            up_block <= 1'b0;
        end else begin
            dn_claim <= dn_req_valid && video_en && dn_hit && dn_space_ok;
            up_block <= up_req_valid && video_en && up_hit;
        end
    end

    // Master abort and unsupported request completions
    always @(posedge aclk) begin
        if (!aresetn) begin
            cpl_valid       <= 1'b0;
            cpl_ur          <= 1'b0;
            cpl_rdata       <= 32'h00000000;
            wr_discard      <= 1'b0;
            err_posted_ma   <= 1'b0;
            up_cpl_valid    <= 1'b0;
            up_target_abort <= 1'b0;
            up_cpl_rdata    <= 32'h00000000;
        end else begin
            cpl_valid     <= ma_valid && !ma_is_posted;
            cpl_ur        <= ma_valid && !ma_is_posted && abort_mode;
            cpl_rdata     <= (ma_valid && ma_is_read && !abort_mode) ?
                             `BCF_ALL_ONES : 32'h00000000;
            wr_discard    <= ma_valid && !ma_is_read;
            err_posted_ma <= ma_valid && ma_is_posted && abort_mode;
            up_cpl_valid    <= ur_cpl_valid;
            up_target_abort <= ur_cpl_valid && abort_mode;
            up_cpl_rdata    <= (ur_cpl_valid && ur_cpl_is_read && !abort_mode) ?
                               `BCF_ALL_ONES : 32'h00000000;
        end
    end

endmodule

`default_nettype wire

// file: sim/bcf_properties.sv
// Checker for the bridge control block, sees only its ports.
// Bound to bcf_bridge_control from the testbench top file.
`timescale 1ns/1ps
`default_nettype none
module bcf_checker (
    input wire        aclk,
    input wire        aresetn,
    input wire        bvalid,
    input wire        dn_req_valid,
    input wire        up_req_valid,
    input wire [31:0] up_req_addr,
    input wire        up_req_is_io,
    input wire        dn_claim,
    input wire        up_block,
    input wire        ma_valid,
    input wire        ma_is_read,
    input wire        ma_is_posted,
    input wire        cpl_valid,
    input wire        cpl_ur,
    input wire [31:0] cpl_rdata,
    input wire        wr_discard,
    input wire        err_posted_ma,
    input wire        ur_cpl_valid,
    input wire        up_cpl_valid,
    input wire        up_target_abort,
    input wire        secondary_back_to_back_enable,
    input wire        secondary_reset_out
);
    wire [9:0] lo     = up_req_addr[9:0];
    wire       io_hit = up_req_addr[31:16] == 16'h0000 &&
        ((lo >= 10'h3B0 && lo <= 10'h3BB) || (lo >= 10'h3C0 && lo <= 10'h3DF));
    wire       up_hit = up_req_is_io ? io_hit :
        (up_req_addr >= 32'h000A0000 && up_req_addr <= 32'h000BFFFF);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_ma_gets_cpl: assert property (ma_valid && !ma_is_posted |=> cpl_valid)
        else $error("no completion after master abort");
    a_posted_dropped: assert property (ma_valid && ma_is_posted |=> wr_discard && !cpl_valid)
        else $error("posted write abort not discarded");
    a_read_all_ones: assert property (ma_valid && ma_is_read && !ma_is_posted
        |=> cpl_ur || cpl_rdata == 32'hFFFFFFFF)
        else $error("aborted read data not all ones");
    a_ur_gets_cpl: assert property (ur_cpl_valid |=> up_cpl_valid)
        else $error("no upstream completion");
    a_ta_has_cause: assert property (up_target_abort |-> up_cpl_valid && $past(ur_cpl_valid))
        else $error("target abort without cause");
    a_err_has_cause: assert property (err_posted_ma |-> wr_discard && $past(ma_is_posted))
        else $error("error signal without posted abort");
    a_block_range: assert property (up_block |-> $past(up_req_valid && up_hit))
        else $error("upstream block outside video range");
    a_claim_cause: assert property (dn_claim |-> $past(dn_req_valid))
        else $error("claim without request");
    a_reset_by_write: assert property ($changed(secondary_reset_out) |-> $past(bvalid))
        else $error("secondary reset moved without write");
    a_b2b_by_write: assert property ($changed(secondary_back_to_back_enable)
        |-> $past(bvalid))
        else $error("back to back enable moved without write");
    c_posted_err: cover property (ma_valid && ma_is_posted ##1 err_posted_ma);
    c_block: cover property (up_block && dn_claim);
    c_tabort: cover property (up_target_abort);
    c_reset_off: cover property ($fell(secondary_reset_out));
endmodule
`default_nettype wire

// file: sim/bcf_far_side.sv
// Far side model: primary link and secondary bus events as pulses.
// Driven right after a rising edge; payload scrambled once released.
`timescale 1ns/1ps
`default_nettype none
module bcf_far_side (
    input  wire         aclk,
    output logic        dn_req_valid,
    output logic [31:0] dn_req_addr,
    output logic        dn_req_is_io,
    output logic        up_req_valid,
    output logic [31:0] up_req_addr,
    output logic        up_req_is_io,
    output logic        ma_valid,
    output logic        ma_is_read,
    output logic        ma_is_posted,
    output logic        ur_cpl_valid,
    output logic        ur_cpl_is_read
);
    initial begin
        {dn_req_valid, dn_req_addr, dn_req_is_io, up_req_valid, up_req_addr} = '0;
        {up_req_is_io, ma_valid, ma_is_read, ma_is_posted} = '0;
        {ur_cpl_valid, ur_cpl_is_read} = '0;
    end
    // Same address offered downstream and upstream at once
    task automatic req(input logic [31:0] a, input logic io);
        dn_req_addr <= a;
        up_req_addr <= a;
        dn_req_is_io <= io;
        up_req_is_io <= io;
        dn_req_valid <= 1'b1;
        up_req_valid <= 1'b1;
        @(posedge aclk);
        dn_req_valid <= 1'b0;
        up_req_valid <= 1'b0;
        dn_req_addr <= ~a;
        up_req_addr <= ~a;
        dn_req_is_io <= ~io;
        up_req_is_io <= ~io;
    endtask
    // Master abort downstream and unsupported request completion upstream
    task automatic abort(input logic rd, input logic posted);
        ma_is_read <= rd;
        ma_is_posted <= posted;
        ur_cpl_is_read <= rd;
        ma_valid <= 1'b1;
        ur_cpl_valid <= 1'b1;
        @(posedge aclk);
        ma_valid <= 1'b0;
        ur_cpl_valid <= 1'b0;
        ma_is_read <= ~rd;
        ma_is_posted <= ~posted;
        ur_cpl_is_read <= ~rd;
    endtask
endmodule
`default_nettype wire

// file: sim/bridge_control_forwarding_tb.sv
// Self-checking bench for the bridge control block.
// Register bus is AXI4-Lite; far side events come from bcf_far_side.
`timescale 1ns/1ps
`default_nettype none
module bridge_control_forwarding_tb;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic        bready = 1'b1, rready = 1'b1;
    wire         awready, wready, bvalid, arready, rvalid, dn_claim, up_block;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata, cpl_rdata, up_cpl_rdata, dn_req_addr, up_req_addr;
    wire         cpl_valid, cpl_ur, wr_discard, err_posted_ma, up_cpl_valid, up_target_abort;
    wire         secondary_back_to_back_enable, secondary_reset_out, legacy_io_block_enable;
    wire         io_space_enable, memory_space_enable, irq;
    wire         dn_req_valid, dn_req_is_io, up_req_valid, up_req_is_io, ma_valid;
    wire         ma_is_read, ma_is_posted, ur_cpl_valid, ur_cpl_is_read;
    int          errors = 0, n_tests = 0, seed = 9, cyc = 0;
    int          ctl = 0, cmd = 0, stat = 0, mask = 0;
    logic [31:0] wd;
    logic [31:0] addrs [12] = '{32'h000A0000, 32'h000BFFFF, 32'h0009FFFF, 32'h000C0000,
        32'h000003B0, 32'h000003BB, 32'h000003BC, 32'h000003C0, 32'h000003DF,
        32'h000003E0, 32'h0000FFC0, 32'h000103C0};

    bcf_bridge_control u_dut (.*);
    bcf_far_side u_far (.*);

    always #12.5 aclk = ~aclk;

    always @(posedge aclk) begin
        cyc = cyc + 1;
        if (cyc == 40000) begin
            errors = errors + 1;
            complete_run;
        end
    end

    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic a_ok, w_ok;
        a_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(a_ok && w_ok)) begin
            @(posedge aclk);
            if (awready === 1'b1) a_ok = 1'b1;
            if (wready === 1'b1) w_ok = 1'b1;
            if (a_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        chk("bresp", er, bresp);
    endtask

    task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        chk("rdata", exp, rdata);
        chk("rresp", er, rresp);
    endtask

    function automatic logic vid_hit(input logic [31:0] a, input logic io);
        logic lo;
        lo = (a[9:0] >= 10'h3B0 && a[9:0] <= 10'h3BB) || (a[9:0] >= 10'h3C0 && a[9:0] <= 10'h3DF);
        if (!ctl[3]) return 1'b0;
        if (!io) return a >= 32'h000A0000 && a <= 32'h000BFFFF;
        return a[31:16] == 16'h0000 && lo && !(ctl[4] && a[15:10] != 6'h00);
    endfunction

    task automatic dec(input logic [31:0] a, input logic io);
        logic hit;
        hit = vid_hit(a, io);
        u_far.req(a, io);
        @(posedge aclk);
        chk("claim,block", {hit && (io ? cmd[0] : cmd[1]), hit}, {dn_claim, up_block});
    endtask

    task automatic ev(input int m, input logic rd, input logic posted);
        u_far.abort(rd, posted);
        if (m == 1) stat = stat | {1'b1, !posted, posted};
        @(posedge aclk);
        chk("abort flags", {!posted, !posted && m == 1, !rd, posted && m == 1, 1'b1, m == 1,
            (stat & mask) != 0}, {cpl_valid, cpl_ur, wr_discard, err_posted_ma,
            up_cpl_valid, up_target_abort, irq});
        chk("cpl_rdata", (!posted && rd && m == 0) ? 32'hFFFFFFFF : 32'h0, cpl_rdata);
        chk("up_cpl_rdata", (rd && m == 0) ? 32'hFFFFFFFF : 32'h0, up_cpl_rdata);
    endtask

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 5; i++) reg_chk(i * 4, 32'h0, 2'h0);
        reg_chk(8'h14, 32'h0, 2'h2);
        axi_write(8'h14, 32'hFFFFFFFF, 2'h2);
        $display("reset and map test done");
        for (int i = 0; i < 16; i++) begin
            wd = $random(seed);
            wd[4:3] = i[1:0];
            ctl = wd & 32'h00000AFF;
            axi_write(8'h00, wd, 2'h0);
            wd = $random(seed);
            wd[1:0] = i[3:2];
            cmd = wd & 32'h3;
            axi_write(8'h04, wd, 2'h0);
            reg_chk(8'h00, ctl, 2'h0);
            reg_chk(8'h04, cmd, 2'h0);
            chk("levels", {ctl[7], ctl[6], ctl[2], cmd[0], cmd[1]}, {secondary_back_to_back_enable,
                secondary_reset_out, legacy_io_block_enable, io_space_enable,
                memory_space_enable});
            reg_chk(8'h10, ctl[6], 2'h0);
            foreach (addrs[j]) begin
                dec(addrs[j], 1'b0);
                dec(addrs[j], 1'b1);
            end
            wd = $random(seed);
            dec({16'h0000, wd[15:0]}, i[0]);
        end
        $display("control and decode test done");
        axi_write(8'h0C, 32'h7, 2'h0);
        mask = 7;
        for (int m = 0; m < 2; m++) begin
            axi_write(8'h00, m << 5, 2'h0);
            ev(m, 1'b1, 1'b0);
            ev(m, 1'b0, 1'b0);
            ev(m, 1'b0, 1'b1);
            reg_chk(8'h08, stat, 2'h0);
        end
        reg_chk(8'h10, 32'h2, 2'h0);
        axi_write(8'h08, 32'h1, 2'h0);
        stat = stat & 6;
        reg_chk(8'h08, stat, 2'h0);
        axi_write(8'h08, 32'h6, 2'h0);
        stat = 0;
        axi_write(8'h0C, 32'h2, 2'h0);
        mask = 2;
        reg_chk(8'h08, 32'h0, 2'h0);
        chk("irq", 1'b0, irq);
        ev(1, 1'b0, 1'b1);
        ev(1, 1'b1, 1'b0);
        $display("abort and interrupt test done");
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        reg_chk(8'h08, 32'h0, 2'h0);
        reg_chk(8'h00, 32'h0, 2'h0);
        reg_chk(8'h0C, 32'h0, 2'h0);
        chk("irq after reset", 1'b0, irq);
        $display("second reset test done");
        complete_run;
    end
endmodule

bind bcf_bridge_control bcf_checker u_chk (.*);
`default_nettype wire
